// *** src/humidity_probe_modbus_regmap.sv ***
// Read-only measurement register bank served to a Modbus request port.
`timescale 1ns/1ps
module humidity_probe_modbus_regmap (
  // Clock and reset.
  input  wire logic                                  I_SYS_CLK,
  input  wire logic                                  I_RST_N,
  // Measurement values from the measurement logic.
  input  wire logic [probe_regmap_pkg::NF-1:0][31:0] I_F32_VALUE,
  input  wire logic [probe_regmap_pkg::NF-1:0]       I_F32_VALID,
  input  wire logic [probe_regmap_pkg::NI-1:0][31:0] I_I32_VALUE,
  input  wire logic [probe_regmap_pkg::NI-1:0]       I_I32_VALID,
  // Request from the protocol engine.
  input  wire logic                                  I_REQ_VALID,
  input  wire logic [7:0]                            I_REQ_FUNC,
  input  wire logic [15:0]                           I_REQ_ADDR,
  input  wire logic [15:0]                           I_REQ_QTY,
  output logic                                       O_REQ_READY,
  // Answer beats to the protocol engine.
  output logic                                       O_RSP_VALID,
  output logic [1:0]                                 O_RSP_KIND,
  output logic [15:0]                                O_RSP_DATA,
  output logic                                       O_RSP_LAST
);

  // ---------------------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------------------
  probe_regmap_pkg::state_t state;       // Current sequencer state.
  probe_regmap_pkg::state_t next_state;  // State for the next cycle.
  logic [31:0] snap_f [probe_regmap_pkg::NF];  // Captured float words.
  logic [15:0] snap_i [probe_regmap_pkg::NI];  // Captured integer codes.
  logic [7:0]  func;      // Function code of the request in progress.
  logic [15:0] base;      // Start address of the request in progress.
  logic [6:0]  qty_m1;    // Quantity minus one, valid once checked.
  logic [6:0]  idx;       // Word counter within the request.
  logic [7:0]  exc_code;  // Exception code to be sent.
  logic [16:0] cur_addr;  // Address of the word under the counter.
  logic        cur_ok;    // Address is inside a defined register.
  logic [15:0] cur_word;  // Word stored at that address.
  logic        accept;    // Request taken on this edge.
  logic        func_ok;   // Function code is served.
  logic        qty_ok;    // Quantity is within the function's limit.
  int_code_if  ibus();    // Raw integers out, codes back.

  // The bank accepts only while idle; the ready flop mirrors that.
  assign accept  = (state == probe_regmap_pkg::ST_IDLE) && I_REQ_VALID;
  assign func_ok = (I_REQ_FUNC == probe_regmap_pkg::FC_READ_HOLDING)
                || (I_REQ_FUNC == probe_regmap_pkg::FC_WRITE_MULTI);
  // A zero quantity or one above the function's limit is refused as a whole.
  assign qty_ok  = (I_REQ_QTY != 16'h0000) &&
                   ((I_REQ_FUNC == probe_regmap_pkg::FC_READ_HOLDING) ?
                    (I_REQ_QTY <= probe_regmap_pkg::READ_QTY_MAX) :
                    (I_REQ_QTY <= probe_regmap_pkg::WRITE_QTY_MAX));
  // One extra bit so that a run past FFFFh never wraps onto address zero.
  assign cur_addr = {1'b0, base} + {10'h000, idx};

  // ---------------------------------------------------------------------------
  // Integer clipping.
  // ---------------------------------------------------------------------------
  assign ibus.raw   = I_I32_VALUE;
  assign ibus.valid = I_I32_VALID;

  // Clipping stays combinational; the snapshot flops register its result.
  int_saturator u_sat (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .bus     (ibus)
  );

  // ---------------------------------------------------------------------------
  // Address decode.
  // ---------------------------------------------------------------------------
  // Addresses are zero based, so register number one decodes at 0000h.
  always_comb begin
    cur_ok   = 1'b0;
    cur_word = probe_regmap_pkg::WORD_RESET;
    for (int i = 0; i < probe_regmap_pkg::NF; i++) begin
      // Low half of the float sits at the listed address.
      if (cur_addr == {1'b0, probe_regmap_pkg::F32_ADDR[i]}) begin
        cur_ok   = 1'b1;
        cur_word = snap_f[i][15:0];
      end
      // High half sits at the address just above it.
      if (cur_addr == {1'b0, probe_regmap_pkg::F32_ADDR[i]} + 17'h00001) begin
        cur_ok   = 1'b1;
        cur_word = snap_f[i][31:16];
      end
    end
    for (int k = 0; k < probe_regmap_pkg::NI; k++) begin
      // Integer registers take one address each.
      if (cur_addr == {1'b0, probe_regmap_pkg::I16_ADDR[k]}) begin
        cur_ok   = 1'b1;
        cur_word = snap_i[k];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Snapshot of the measurement inputs.
  // ---------------------------------------------------------------------------
  // All values are caught on the accept edge so that the two halves of a float,
  // and all words of a long read, come from the same measurement instant. The
  // cost is one copy of every value; a live read could tear a float in two.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < probe_regmap_pkg::NF; i++) begin
        snap_f[i] <= probe_regmap_pkg::F32_QUIET_NAN;
      end
      for (int k = 0; k < probe_regmap_pkg::NI; k++) begin
        snap_i[k] <= probe_regmap_pkg::I16_NA_CODE;
      end
    end else if (accept) begin
      for (int i = 0; i < probe_regmap_pkg::NF; i++) begin
        // A missing float is replaced, never reported as an error.
        snap_f[i] <= I_F32_VALID[i] ? I_F32_VALUE[i]
                                    : probe_regmap_pkg::F32_QUIET_NAN;
      end
      for (int k = 0; k < probe_regmap_pkg::NI; k++) begin
        snap_i[k] <= ibus.code[k];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer next state.
  // ---------------------------------------------------------------------------
  // Every address is checked before any data goes out, because an exception
  // must replace the whole answer rather than follow a partial one.
  always_comb begin
    next_state = state;
    unique case (state)
      probe_regmap_pkg::ST_IDLE: begin
        if (I_REQ_VALID) begin
          // Bad function or quantity is refused without scanning.
          next_state = (func_ok && qty_ok) ? probe_regmap_pkg::ST_SCAN
                                           : probe_regmap_pkg::ST_EXC;
        end
      end
      probe_regmap_pkg::ST_SCAN: begin
        if (!cur_ok) begin
          next_state = probe_regmap_pkg::ST_EXC;
        end else if (idx == qty_m1) begin
          // Writes touch no storage here; they are acknowledged as a whole.
          next_state = (func == probe_regmap_pkg::FC_READ_HOLDING) ?
                       probe_regmap_pkg::ST_STREAM : probe_regmap_pkg::ST_WACK;
        end
      end
      probe_regmap_pkg::ST_STREAM: begin
        if (idx == qty_m1) begin
          next_state = probe_regmap_pkg::ST_IDLE;
        end
      end
      probe_regmap_pkg::ST_EXC: begin
        next_state = probe_regmap_pkg::ST_IDLE;
      end
      probe_regmap_pkg::ST_WACK: begin
        next_state = probe_regmap_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sequencer state and ready.
  // ---------------------------------------------------------------------------
  // Ready is registered from the next state so it is high exactly while idle.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state       <= probe_regmap_pkg::ST_IDLE;
      O_REQ_READY <= 1'b1;
    end else begin
      state       <= next_state;
      O_REQ_READY <= (next_state == probe_regmap_pkg::ST_IDLE);
    end
  end

  // ---------------------------------------------------------------------------
  // Request fields and word counter.
  // ---------------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      func     <= 8'h00;
      base     <= probe_regmap_pkg::WORD_RESET;
      qty_m1   <= probe_regmap_pkg::IDX_RESET;
      idx      <= probe_regmap_pkg::IDX_RESET;
      exc_code <= 8'h00;
    end else begin
      if (accept) begin
        // Fields are held for the whole request; the port may change freely.
        func   <= I_REQ_FUNC;
        base   <= I_REQ_ADDR;
        qty_m1 <= 7'(I_REQ_QTY - 16'h0001);
        idx    <= probe_regmap_pkg::IDX_RESET;
        // Function errors take priority over quantity errors.
        exc_code <= func_ok ? probe_regmap_pkg::EXC_BAD_QUANTITY
                            : probe_regmap_pkg::EXC_BAD_FUNCTION;
      end else if (state == probe_regmap_pkg::ST_SCAN) begin
        if (!cur_ok) begin
          exc_code <= probe_regmap_pkg::EXC_BAD_ADDRESS;
        end
        // The counter restarts for the data phase after the last check.
        idx <= (idx == qty_m1) ? probe_regmap_pkg::IDX_RESET : idx + 7'h01;
      end else if (state == probe_regmap_pkg::ST_STREAM) begin
        idx <= idx + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Answer beats.
  // ---------------------------------------------------------------------------
  // Each beat is registered, so it trails its state by one cycle.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RSP_VALID <= 1'b0;
      O_RSP_KIND  <= probe_regmap_pkg::KIND_DATA;
      O_RSP_DATA  <= probe_regmap_pkg::WORD_RESET;
      O_RSP_LAST  <= 1'b0;
    end else begin
      O_RSP_VALID <= 1'b0;
      O_RSP_LAST  <= 1'b0;
      if (state == probe_regmap_pkg::ST_STREAM) begin
        // Missing values already sit in the snapshot as NaN or 8000h.
        O_RSP_VALID <= 1'b1;
        O_RSP_KIND  <= probe_regmap_pkg::KIND_DATA;
        O_RSP_DATA  <= cur_word;
        O_RSP_LAST  <= (idx == qty_m1);
      end else if (state == probe_regmap_pkg::ST_EXC) begin
        O_RSP_VALID <= 1'b1;
        O_RSP_KIND  <= probe_regmap_pkg::KIND_EXC;
        O_RSP_DATA  <= {8'h00, exc_code};
        O_RSP_LAST  <= 1'b1;
      end else if (state == probe_regmap_pkg::ST_WACK) begin
        // The acknowledgement echoes the quantity written.
        O_RSP_VALID <= 1'b1;
        O_RSP_KIND  <= probe_regmap_pkg::KIND_WACK;
        O_RSP_DATA  <= {9'h000, qty_m1} + 16'h0001;
        O_RSP_LAST  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  // A missing float is captured as the quiet NaN.
  a_float_nan_fill: assert property (accept && !I_F32_VALID[0]
    |=> snap_f[0] == 32'h7FC00000)
    else $error("missing float not captured as quiet NaN");

  // A hole in the map ends in an address exception two cycles later.
  a_exc_bad_addr: assert property (state == probe_regmap_pkg::ST_SCAN && !cur_ok
    |=> ##1 O_RSP_VALID && O_RSP_KIND == 2'h2 && O_RSP_DATA == 16'h0002)
    else $error("address outside map not answered by exception 02");

  // A fully defined read never yields an exception.
  a_no_exc_inside: assert property (state == probe_regmap_pkg::ST_SCAN && cur_ok
    && idx == qty_m1 && func == 8'h03 |=> ##1 O_RSP_VALID && O_RSP_KIND == 2'h0)
    else $error("defined read did not start with data");

  // Unknown function codes are refused with code 01.
  a_bad_func_exc: assert property (accept && I_REQ_FUNC != 8'h03
    && I_REQ_FUNC != 8'h10 |=> ##1 O_RSP_VALID && O_RSP_DATA == 16'h0001)
    else $error("unsupported function not refused with 01");

  // Low float word comes at the listed address, high word at the next one.
  a_float_word_order: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00024 |=> O_RSP_DATA == snap_f[probe_regmap_pkg::F_SAT_RATIO][15:0])
    else $error("float low word not at base address");
  a_float_high_word: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00027 |=> O_RSP_DATA == snap_f[probe_regmap_pkg::F_SENS_TEMP][31:16])
    else $error("sensor temperature high word misplaced");

  // Integer diagnostic and NTP registers land at their fixed addresses.
  a_int_ntp_addr: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00110 |=> O_RSP_DATA == snap_i[probe_regmap_pkg::I_ABS_HUM_NTP])
    else $error("address 0110h not serving NTP absolute humidity");
  a_int_diag_addr: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00112 |=> O_RSP_DATA == snap_i[probe_regmap_pkg::I_SAT_RATIO])
    else $error("address 0112h not serving saturation ratio");

  // The snapshot holds still for the whole request.
  a_snap_stable: assert property (!accept |=> $stable(snap_f[0])
    && $stable(snap_i[probe_regmap_pkg::I_SENS_TEMP]))
    else $error("snapshot changed outside an accept");

  // A missing integer is captured as 8000h, never as a stale number.
  a_int_na_capture: assert property (accept
    && !I_I32_VALID[probe_regmap_pkg::I_SENS_TEMP]
    |=> snap_i[probe_regmap_pkg::I_SENS_TEMP] == 16'h8000)
    else $error("missing integer not captured as 8000h");

  // An exception is a single beat that ends the answer.
  a_exc_single_beat: assert property (O_RSP_VALID && O_RSP_KIND == 2'h2
    |-> O_RSP_LAST)
    else $error("exception beat not marked last");

  // Register number one is served at address zero, low float word first.
  a_zero_based_addr: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00000 |=> O_RSP_DATA == snap_f[0][15:0])
    else $error("address 0000h not serving the first float low word");

  // The last float closes the float range with its high word at 0041h.
  a_float_last_half: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00041
    |=> O_RSP_DATA == snap_f[probe_regmap_pkg::NF-1][31:16])
    else $error("address 0041h not serving the last float high word");

  // The first integer register sits alone at 0100h.
  a_int_first_addr: assert property (state == probe_regmap_pkg::ST_STREAM
    && cur_addr == 17'h00100 |=> O_RSP_DATA == snap_i[0])
    else $error("address 0100h not serving the first integer");

  // A write inside the map is answered by one acknowledgement beat.
  a_write_ack_beat: assert property (state == probe_regmap_pkg::ST_WACK
    |=> O_RSP_VALID && O_RSP_LAST && O_RSP_KIND == 2'h1)
    else $error("write inside the map not acknowledged");

  // Scenarios worth reaching.
  c_read_done: cover property (O_RSP_VALID && O_RSP_LAST && O_RSP_KIND == 2'h0);
  c_exception: cover property (O_RSP_VALID && O_RSP_KIND == 2'h2);
  c_write_ack: cover property (O_RSP_VALID && O_RSP_KIND == 2'h1);
  c_nan_read:  cover property (O_RSP_VALID && O_RSP_DATA == 16'h7FC0);
  // A data beat that carries the not-available integer code.
  c_int_missing: cover property (O_RSP_VALID && O_RSP_KIND == 2'h0 && O_RSP_DATA == 16'h8000);

endmodule

// *** shared/probe_regmap_pkg.sv ***
// Constants, address map and types shared by the probe register bank.
package probe_regmap_pkg;

  // ---------------------------------------------------------------------------
  // Sizes of the two register families.
  // ---------------------------------------------------------------------------
  localparam int NF = 17;  // Number of two-word float registers.
  localparam int NI = 17;  // Number of one-word integer registers.

  // ---------------------------------------------------------------------------
  // Function codes and exception codes of the request port.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLDING  = 8'h03;  // Read holding registers.
  localparam logic [7:0] FC_WRITE_MULTI   = 8'h10;  // Write multiple registers.
  localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;  // Function code not served.
  localparam logic [7:0] EXC_BAD_ADDRESS  = 8'h02;  // Address outside the map.
  localparam logic [7:0] EXC_BAD_QUANTITY = 8'h03;  // Quantity out of range.
  localparam logic [15:0] READ_QTY_MAX    = 16'h007D;  // Largest read, 125 words.
  localparam logic [15:0] WRITE_QTY_MAX   = 16'h007B;  // Largest write, 123 words.

  // ---------------------------------------------------------------------------
  // Zero-based protocol addresses: register number minus one.
  // ---------------------------------------------------------------------------
  localparam logic [15:0] F32_ADDR [NF] = '{
    16'h0000, 16'h0002, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010,
    16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001E, 16'h0020, 16'h0024, 16'h0026,
    16'h0040};
  localparam logic [15:0] I16_ADDR [NI] = '{
    16'h0100, 16'h0101, 16'h0103, 16'h0104, 16'h0105, 16'h0106, 16'h0107, 16'h0108,
    16'h010A, 16'h010B, 16'h010C, 16'h010D, 16'h010F, 16'h0110, 16'h0112, 16'h0113,
    16'h0120};
  // Scale applied upstream to each integer value before it reaches the bank.
  localparam logic [7:0] I16_SCALE [NI] = '{
    8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h64,
    8'h01, 8'h0A, 8'h0A, 8'h64, 8'h0A, 8'h64, 8'h64, 8'h64, 8'h01};

  // Indices of the entries that are checked individually.
  localparam int F_SAT_RATIO  = 14;  // Float sensor saturation ratio.
  localparam int F_SENS_TEMP  = 15;  // Float sensor temperature.
  localparam int I_ABS_HUM_NTP = 13;  // Integer absolute_humidity_ntp_i16.
  localparam int I_SAT_RATIO  = 14;  // Integer sensor saturation ratio.
  localparam int I_SENS_TEMP  = 15;  // Integer sensor temperature.

  // ---------------------------------------------------------------------------
  // Codes returned in place of a missing or out-of-range value.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] F32_QUIET_NAN = 32'h7FC00000;  // Missing float.
  localparam logic [15:0] I16_NA_CODE   = 16'h8000;      // Missing integer.
  localparam logic [15:0] I16_MAX_CODE  = 16'h7FFF;      // 32767 or larger.
  localparam logic [15:0] I16_MIN_CODE  = 16'h8001;      // -32767 or smaller.
  localparam logic signed [31:0] SAT_HI = 32'sh00007FFF;  // Upper clip point.
  localparam logic signed [31:0] SAT_LO = 32'shFFFF8001;  // Lower clip point.

  // ---------------------------------------------------------------------------
  // Reset values and answer kinds.
  // ---------------------------------------------------------------------------
  localparam logic [6:0]  IDX_RESET  = 7'h00;   // Word counter after reset.
  localparam logic [15:0] WORD_RESET = 16'h0000;  // Data output after reset.
  localparam logic [1:0]  KIND_DATA  = 2'h0;  // Beat carries a register word.
  localparam logic [1:0]  KIND_WACK  = 2'h1;  // Beat acknowledges a write.
  localparam logic [1:0]  KIND_EXC   = 2'h2;  // Beat carries an exception code.

  // Request sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_STREAM, ST_EXC, ST_WACK} state_t;

endpackage

// *** shared/int_code_if.sv ***
// Interface that carries raw integer values to the saturator and codes back.
`timescale 1ns/1ps
interface int_code_if;
  logic [probe_regmap_pkg::NI-1:0][31:0] raw;    // Scaled values, two's complement.
  logic [probe_regmap_pkg::NI-1:0]       valid;  // Value present flags.
  logic [probe_regmap_pkg::NI-1:0][15:0] code;   // Saturated register codes.
  modport sat  (input raw, input valid, output code);
  modport bank (output raw, output valid, input code);
endinterface

// *** src/int_saturator.sv ***
// Per-channel clipping of scaled integer values into 16-bit register codes.
`timescale 1ns/1ps
module int_saturator (
  // Clock and reset, used only by the checks.
  input wire logic   i_clk,
  input wire logic   i_rst_n,
  // Value and code bundle.
  int_code_if.sat    bus
);

  // ---------------------------------------------------------------------------
  // One clipper per integer register.
  // ---------------------------------------------------------------------------
  genvar j;
  generate
    for (j = 0; j < probe_regmap_pkg::NI; j++) begin : g_ch
      // Missing wins over any stale raw value; 8000h never encodes a number.
      always_comb begin
        if (!bus.valid[j]) begin
          bus.code[j] = probe_regmap_pkg::I16_NA_CODE;
        end else if ($signed(bus.raw[j]) >= probe_regmap_pkg::SAT_HI) begin
          bus.code[j] = probe_regmap_pkg::I16_MAX_CODE;
        end else if ($signed(bus.raw[j]) <= probe_regmap_pkg::SAT_LO) begin
          bus.code[j] = probe_regmap_pkg::I16_MIN_CODE;
        end else begin
          bus.code[j] = bus.raw[j][15:0];
        end
      end

      // Checks on the clipping of this channel.
      a_int_na_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !bus.valid[j] |-> bus.code[j] == 16'h8000)
        else $error("missing integer not coded as 8000h");
      a_int_sat_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        bus.valid[j] && $signed(bus.raw[j]) > 32'sd32766 |-> bus.code[j] == 16'h7FFF)
        else $error("large integer not clipped to 7FFFh");
      a_int_sat_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        bus.valid[j] && $signed(bus.raw[j]) < -32'sd32766 |-> bus.code[j] == 16'h8001)
        else $error("small integer not clipped to 8001h");
    end
  endgenerate

endmodule

// *** test/req_master.sv ***
// Request-side model of the protocol engine that talks to the register bank.
`timescale 1ns/1ps
module req_master (
  // Clock and answer beats.
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  input  wire logic        i_rsp_valid,
  input  wire logic [1:0]  i_rsp_kind,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_rsp_last,
  // Request lines.
  output logic             o_valid,
  output logic [7:0]       o_func,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_qty
);
  logic [15:0] words [$];  // Beats of the last answer.
  logic [1:0]  kind;       // Kind of the last answer.
  initial o_valid = 1'b0;
  // One request, held until taken, then every beat up to the last one.
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
    int n;
    n = 0;
    words = {};
    @(posedge i_clk);
    o_func  <= f;
    o_addr  <= a;
    o_qty   <= q;
    o_valid <= 1'b1;
    @(posedge i_clk);
    while (i_ready !== 1'b1) @(posedge i_clk);
    // Released lines show the inverse so a stale value is never mistaken for a hold.
    o_valid <= 1'b0;
    o_func  <= ~f;
    o_addr  <= ~a;
    o_qty   <= ~q;
    do begin
      @(negedge i_clk);
      if (i_rsp_valid === 1'b1) begin
        words.push_back(i_rsp_data);
        kind = i_rsp_kind;
      end
      n++;
    end while (!(i_rsp_valid === 1'b1 && i_rsp_last === 1'b1) && n < 400);
  endtask
endmodule

// *** test/tb_humidity_probe_modbus_regmap.sv ***
// Self-checking bench of the probe register bank.
`timescale 1ns/1ps
module tb_humidity_probe_modbus_regmap;
  logic clk, rst_n, rv, rdy, ov, last;
  logic [16:0][31:0] fv, iv, sf, si;  // Live values and accept-edge snapshots.
  logic [16:0] fok, iok, sfok, siok;
  logic [7:0] fn;
  logic [15:0] ad, qt, dat;
  logic [1:0] kd;
  logic [31:0] seed, r;
  int n_errors, num_checks;
  humidity_probe_modbus_regmap dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_F32_VALUE(fv),
    .I_F32_VALID(fok), .I_I32_VALUE(iv), .I_I32_VALID(iok), .I_REQ_VALID(rv), .I_REQ_FUNC(fn),
    .I_REQ_ADDR(ad), .I_REQ_QTY(qt), .O_REQ_READY(rdy), .O_RSP_VALID(ov), .O_RSP_KIND(kd),
    .O_RSP_DATA(dat), .O_RSP_LAST(last));
  req_master m (.i_clk(clk), .i_ready(rdy), .i_rsp_valid(ov), .i_rsp_kind(kd),
    .i_rsp_data(dat), .i_rsp_last(last), .o_valid(rv), .o_func(fn), .o_addr(ad), .o_qty(qt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected word at one address from the snapshot; hit is low for a hole.
  function automatic logic [15:0] exp_w(input logic [15:0] a, output logic hit);
    logic [31:0] w;
    hit = 1'b0;
    exp_w = 16'h0000;
    for (int i = 0; i < 17; i++) begin
      if (a[15:1] == probe_regmap_pkg::F32_ADDR[i][15:1]) begin
        hit = 1'b1;
        w = sfok[i] ? sf[i] : probe_regmap_pkg::F32_QUIET_NAN;
        exp_w = a[0] ? w[31:16] : w[15:0];
      end
      if (a == probe_regmap_pkg::I16_ADDR[i]) begin
        hit = 1'b1;
        if (!siok[i]) exp_w = probe_regmap_pkg::I16_NA_CODE;
        else if ($signed(si[i]) >= probe_regmap_pkg::SAT_HI) exp_w = 16'h7FFF;
        else if ($signed(si[i]) <= probe_regmap_pkg::SAT_LO) exp_w = 16'h8001;
        else exp_w = si[i][15:0];
      end
    end
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One request and a comparison of its whole answer.
  task automatic run(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
    logic [15:0] ew [$];
    logic [1:0] ek;
    logic hit;
    m.xfer(f, a, q);
    chk("last", 16'h0003, {14'h0000, ov, last});
    ek = probe_regmap_pkg::KIND_DATA;
    ew = {};
    if (f != 8'h03 && f != 8'h10) begin
      ek = probe_regmap_pkg::KIND_EXC;
      ew = {16'h0001};
    end else if (q == 16'h0000 || q > (f == 8'h03 ? 16'h007D : 16'h007B)) begin
      ek = probe_regmap_pkg::KIND_EXC;
      ew = {16'h0003};
    end else begin
      for (int j = 0; j < int'(q); j++) begin
        ew.push_back(exp_w(a + 16'(j), hit));
        if (!hit) ek = probe_regmap_pkg::KIND_EXC;
      end
      if (ek == probe_regmap_pkg::KIND_EXC) ew = {16'h0002};
      else if (f == 8'h10) begin
        ek = probe_regmap_pkg::KIND_WACK;
        ew = {q};
      end
    end
    chk("kind", {14'h0000, ek}, {14'h0000, m.kind});
    chk("beats", 16'(ew.size()), 16'(m.words.size()));
    foreach (ew[j]) chk("word", ew[j], m.words[j]);
  endtask
  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Snapshot at the accept edge, and one float and one integer value disturbed every cycle.
  always @(posedge clk) begin
    if (rv && rdy) {sf, si, sfok, siok} = {fv, iv, fok, iok};
    r = rnd();
    fv[r[4:0] % 5'd17] <= rnd();
    iv[r[9:5] % 5'd17] <= r[30] ? rnd() : {{16{r[27]}}, r[27:12]};
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
  initial begin
    {seed, rst_n, fv, iv, fok, iok, n_errors, num_checks} = '0;
    seed = 32'h6CE78D34;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    run(8'h03, 16'h0000, 16'h0002);
    run(8'h03, 16'h0024, 16'h0004);
    run(8'h03, 16'h0110, 16'h0001);
    run(8'h03, 16'h0112, 16'h0002);
    run(8'h03, 16'h0041, 16'h0001);
    run(8'h03, 16'h0004, 16'h0001);
    run(8'h03, 16'h0121, 16'h0001);
    run(8'h03, 16'hFFFF, 16'h0002);
    run(8'h05, 16'h0000, 16'h0001);
    run(8'h03, 16'h0000, 16'h0000);
    run(8'h03, 16'h0000, 16'h007E);
    run(8'h10, 16'h0100, 16'h0001);
    run(8'h10, 16'h0004, 16'h0001);
    repeat (300) begin
      r = rnd();
      @(posedge clk);
      fok <= r[16:0];
      iok <= r[31:15];
      r = rnd();
      run(r[5:4] == 2'h3 ? 8'h10 : 8'h03, r[1] ? 16'h0100 + 16'(r[15:8] % 8'h21)
        : 16'(r[15:8] % 8'h42), {14'h0000, r[3:2]} + 16'h0001);
    end
    close_out();
  end
endmodule
